// *** hdl/dmr_refresh_top.sv ***
// apb-controlled refresh and multiplex timing for a dot matrix display
module dmr_refresh_top (
  input wire logic sys_clk_in, // controller clock, 100 MHz
  input wire logic nrst_in, // async reset, active low
  input wire logic psel_in, // apb select
  input wire logic penable_in, // apb access phase
  input wire logic pwrite_in, // apb direction, high for write
  input wire logic [11:0] paddr_in, // apb byte address
  input wire logic [31:0] pwdata_in, // apb write data
  output logic [31:0] prdata_out, // apb read data
  output logic pready_out, // apb ready
  output logic pslverr_out, // apb error on unmapped address
  input wire logic slave_sync_in, // start pulse from a master, async
  output logic slave_sync_pulse_out, // start pulse to slaves
  output logic [4:0] grid_sel_out, // scanned position
  output logic grid_active_out, // grid and anodes may be on
  output logic [6:0] char_code_out, // character code for the font decoder
  output logic dot_on_out, // dots enabled
  output logic dot_invert_out, // dots complemented
  output logic cursor_out // cursor segment on
);
  logic [7:0] buf_mem [32];
  dmr_pkg::dmr_slot_type slot_reg;
  dmr_pkg::dmr_mode_type mode_reg;
  dmr_pkg::dmr_run_type run_reg;
  logic [5:0] duty_reg;
  logic [4:0] grid_reg;
  logic [4:0] ptr_reg;
  logic master_reg;
  logic [31:0] prdata_reg;
  logic sync_meta_reg;
  logic sync_sync_reg;
  logic sync_prev_reg;
  logic sync_rise;
  logic [5:0] grid_eff;
  logic [6:0] slot_len;
  logic [6:0] on_time;
  logic [4:0] scan_pos;
  logic scan_active;
  logic [7:0] cur_byte;
  logic attr;
  dmr_pkg::dmr_cmd_type cmd;
  logic [7:0] arg;
  logic addr_ok;
  logic apb_wr;
  logic byte_valid;
  logic [31:0] status_word;

  // ---------------- apb slave ----------------
  // unmapped addresses read as zero and raise pslverr
  assign addr_ok = (paddr_in == dmr_pkg::dmr_addr_data) || (paddr_in == dmr_pkg::dmr_addr_status)
                   || (paddr_in == dmr_pkg::dmr_addr_config);
  // zero wait states: read data is captured in the setup cycle
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in && penable_in && !addr_ok;
  assign apb_wr = psel_in && penable_in && pwrite_in && addr_ok;
  assign byte_valid = apb_wr && (paddr_in == dmr_pkg::dmr_addr_data);
  assign prdata_out = prdata_reg;

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[dmr_pkg::dmr_st_run_pos] = (run_reg == dmr_pkg::dmr_running);
    status_word[dmr_pkg::dmr_st_mode_pos +: 2] = mode_reg;
    status_word[dmr_pkg::dmr_st_slot_pos +: 2] = slot_reg;
    status_word[dmr_pkg::dmr_st_duty_pos +: 6] = duty_reg;
    status_word[dmr_pkg::dmr_st_grid_pos +: 5] = grid_reg;
    status_word[dmr_pkg::dmr_st_ptr_pos +: 5] = ptr_reg;
    status_word[dmr_pkg::dmr_st_scan_pos +: 5] = scan_pos;
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      prdata_reg <= 32'h0000_0000;
    end else if (psel_in && !penable_in) begin
      if (paddr_in == dmr_pkg::dmr_addr_status)
        prdata_reg <= status_word;
      else if (paddr_in == dmr_pkg::dmr_addr_config)
        prdata_reg <= {31'h0000_0000, master_reg};
      else
        prdata_reg <= 32'h0000_0000;
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      master_reg <= dmr_pkg::dmr_master_rst;
    end else if (apb_wr && paddr_in == dmr_pkg::dmr_addr_config) begin
      master_reg <= pwdata_in[dmr_pkg::dmr_cfg_master_pos];
    end
  end

  // ---------------- command decode ----------------
  dmr_cmd_decode u_decode (
    .sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in),
    .byte_valid_in(byte_valid),
    .byte_in(pwdata_in[7:0]),
    .cmd_out(cmd),
    .arg_out(arg)
  );

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      slot_reg <= dmr_pkg::dmr_slot64;
    end else if (cmd == dmr_pkg::dmr_do_slot) begin
      unique case (arg)
        dmr_pkg::dmr_cmd_slot16: slot_reg <= dmr_pkg::dmr_slot16;
        dmr_pkg::dmr_cmd_slot32: slot_reg <= dmr_pkg::dmr_slot32;
        default: slot_reg <= dmr_pkg::dmr_slot64;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mode_reg <= dmr_pkg::dmr_mode_normal;
    end else if (cmd == dmr_pkg::dmr_do_mode) begin
      unique case (arg)
        dmr_pkg::dmr_cmd_blank: mode_reg <= dmr_pkg::dmr_mode_blank;
        dmr_pkg::dmr_cmd_inverse: mode_reg <= dmr_pkg::dmr_mode_inverse;
        default: mode_reg <= dmr_pkg::dmr_mode_normal;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      duty_reg <= dmr_pkg::dmr_duty_rst;
    end else if (cmd == dmr_pkg::dmr_do_duty) begin
      duty_reg <= arg[5:0];
    end
  end

  // grid count may change at any time; the scan wraps at the next slot end
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      grid_reg <= dmr_pkg::dmr_grid_rst;
    end else if (cmd == dmr_pkg::dmr_do_grid) begin
      grid_reg <= arg[4:0];
    end
  end

  assign grid_eff = dmr_pkg::dmr_grid_eff(grid_reg);

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ptr_reg <= dmr_pkg::dmr_ptr_rst;
    end else if (cmd == dmr_pkg::dmr_do_ptr) begin
      ptr_reg <= arg[4:0];
    end else if (cmd == dmr_pkg::dmr_do_data) begin
      if ({1'b0, ptr_reg} + 6'h01 == grid_eff)
        ptr_reg <= dmr_pkg::dmr_ptr_rst;
      else
        ptr_reg <= ptr_reg + 5'h01;
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < 32; i++)
        buf_mem[i] <= dmr_pkg::dmr_byte_rst;
    end else if (cmd == dmr_pkg::dmr_do_data) begin
      buf_mem[ptr_reg] <= arg;
    end
  end

  // ---------------- start and multi-controller sync ----------------
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sync_meta_reg <= 1'b0;
      sync_sync_reg <= 1'b0;
      sync_prev_reg <= 1'b0;
    end else begin
      sync_meta_reg <= slave_sync_in;
      sync_sync_reg <= sync_meta_reg;
      sync_prev_reg <= sync_sync_reg;
    end
  end

  assign sync_rise = sync_sync_reg && !sync_prev_reg;

  // a slave ignores the start code and waits for the master's pulse
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      run_reg <= dmr_pkg::dmr_halted;
    end else if (cmd == dmr_pkg::dmr_do_start && master_reg) begin
      run_reg <= dmr_pkg::dmr_running;
    end else if (sync_rise && !master_reg) begin
      run_reg <= dmr_pkg::dmr_running;
    end
  end

  // the sync pulse goes out in the same cycle the master starts; on a shared clock a slave starts three cycles later, after its synchronizer
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      slave_sync_pulse_out <= 1'b0;
    end else begin
      slave_sync_pulse_out <= (cmd == dmr_pkg::dmr_do_start) && master_reg
                              && (run_reg == dmr_pkg::dmr_halted);
    end
  end

  // ---------------- scan ----------------
  assign slot_len = dmr_pkg::dmr_slot_len(slot_reg);
  assign on_time = dmr_pkg::dmr_on_time(duty_reg, slot_reg);

  dmr_scan_timer u_timer (
    .sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in),
    .run_in(run_reg == dmr_pkg::dmr_running),
    .slot_len_in(slot_len),
    .on_time_in(on_time),
    .grid_count_in(grid_eff),
    .pos_out(scan_pos),
    .active_out(scan_active)
  );

  assign cur_byte = buf_mem[scan_pos];
  assign attr = cur_byte[7];

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      grid_sel_out <= dmr_pkg::dmr_ptr_rst;
      char_code_out <= 7'h00;
      grid_active_out <= 1'b0;
    end else begin
      grid_sel_out <= scan_pos;
      char_code_out <= cur_byte[6:0];
      grid_active_out <= scan_active;
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      dot_on_out <= 1'b0;
      dot_invert_out <= 1'b0;
      cursor_out <= 1'b0;
    end else begin
      dot_on_out <= scan_active && !(attr && mode_reg == dmr_pkg::dmr_mode_blank);
      dot_invert_out <= scan_active && attr && mode_reg == dmr_pkg::dmr_mode_inverse;
      cursor_out <= scan_active && attr;
    end
  end

  // ---------------- checks ----------------
  // length of the current lit run, so the cap needs no long repetition
  logic [6:0] act_run_cnt;

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in)
      act_run_cnt <= 7'h00;
    else if (grid_active_out)
      act_run_cnt <= act_run_cnt + 7'h01;
    else
      act_run_cnt <= 7'h00;
  end

  default clocking dmr_cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!nrst_in);

  active_cap_a: assert property (act_run_cnt <= dmr_pkg::dmr_slot64_len - dmr_pkg::dmr_gap_len)
    else $error("drivers active longer than the slot allows");

  dark_gap_a: assert property ($fell(grid_active_out) |-> !grid_active_out [*3])
    else $error("fewer than three dark cycles between positions");

  low_duty_a: assert property (duty_reg <= dmr_pkg::dmr_duty_offset |=> !grid_active_out)
    else $error("display lit with duty at or below two");

  halt_dark_a: assert property (run_reg == dmr_pkg::dmr_halted |=> !grid_active_out && !cursor_out)
    else $error("outputs active while halted");

  blank_dots_a: assert property (cursor_out && $past(mode_reg) == dmr_pkg::dmr_mode_blank
                                 |-> !dot_on_out && grid_active_out)
    else $error("flagged character not blanked");

  inverse_only_a: assert property (dot_invert_out |-> cursor_out && dot_on_out
                                   && $past(mode_reg) == dmr_pkg::dmr_mode_inverse)
    else $error("inversion without flag or inverse mode");

  normal_shown_a: assert property (grid_active_out && $past(mode_reg) == dmr_pkg::dmr_mode_normal
                                   |-> dot_on_out && !dot_invert_out)
    else $error("normal mode altered the pattern");

  cursor_flag_a: assert property (grid_active_out |-> cursor_out == $past(attr))
    else $error("cursor does not follow the attribute");

  ptr_wrap_a: assert property (cmd == dmr_pkg::dmr_do_data && {1'b0, ptr_reg} + 6'h01 == grid_eff
                               |=> ptr_reg == 5'h00)
    else $error("pointer did not wrap at grid count");

  ptr_step_a: assert property (cmd == dmr_pkg::dmr_do_data && {1'b0, ptr_reg} + 6'h01 != grid_eff
                               |=> ptr_reg == $past(ptr_reg) + 5'h01)
    else $error("pointer did not advance after a data byte");

  duty_load_a: assert property (cmd == dmr_pkg::dmr_do_duty |=> duty_reg == $past(arg[5:0]))
    else $error("duty register not loaded");

  grid_load_a: assert property (cmd == dmr_pkg::dmr_do_grid |=> grid_reg == $past(arg[4:0]))
    else $error("grid count not loaded");

  sync_pulse_a: assert property (cmd == dmr_pkg::dmr_do_start && master_reg && run_reg == dmr_pkg::dmr_halted
                                 |=> slave_sync_pulse_out ##1 !slave_sync_pulse_out)
    else $error("master start did not give a one-cycle sync pulse");

  slave_hold_a: assert property (cmd == dmr_pkg::dmr_do_start && !master_reg && !sync_rise
                                 && run_reg == dmr_pkg::dmr_halted |=> run_reg == dmr_pkg::dmr_halted)
    else $error("slave acted on the start code");

  unused_cmd_a: assert property (cmd == dmr_pkg::dmr_do_none |=> $stable(duty_reg) && $stable(grid_reg)
                                 && $stable(ptr_reg) && $stable(mode_reg) && $stable(slot_reg))
    else $error("ignored code changed state");

  slave_start_a: assert property (sync_rise && !master_reg
                                  |=> run_reg == dmr_pkg::dmr_running)
    else $error("slave did not start on the sync edge");

  master_start_a: assert property (cmd == dmr_pkg::dmr_do_start && master_reg
                                   |=> run_reg == dmr_pkg::dmr_running)
    else $error("master did not start on the start code");

  slot_load_a: assert property (cmd == dmr_pkg::dmr_do_slot && arg == dmr_pkg::dmr_cmd_slot16
                                |=> slot_reg == dmr_pkg::dmr_slot16)
    else $error("short slot not selected");

  mode_load_a: assert property (cmd == dmr_pkg::dmr_do_mode && arg == dmr_pkg::dmr_cmd_inverse
                                |=> mode_reg == dmr_pkg::dmr_mode_inverse)
    else $error("inverse mode not selected");

  ptr_load_a: assert property (cmd == dmr_pkg::dmr_do_ptr
                               |=> ptr_reg == $past(arg[4:0]))
    else $error("pointer not loaded");

  data_store_a: assert property (cmd == dmr_pkg::dmr_do_data
                                 |=> buf_mem[$past(ptr_reg)] == $past(arg))
    else $error("display byte not stored at the pointer");

  char_code_a: assert property (grid_active_out
                                |-> char_code_out == $past(cur_byte[6:0]))
    else $error("character code does not match the stored byte");
endmodule

// *** hdl/dmr_pkg.sv ***
// constants, types and helper functions of the dot matrix refresh controller
// Behaviour
// - command 0x80..0x9f loads grid count from low five bits; zero means 32
// - each character slot lasts 16, 32 or 64 clock cycles
// - active at most 13, 29 or 61 cycles per slot; three dark cycles remain
// - command 0x40..0x7f loads low six bits into the brightness duty register
// - active time is zero for duty 0..2, else duty minus 2, capped
// - slot length is 64 cycles after reset until changed
// - display byte: low seven bits are the code, top bit is the attribute
// - blank mode suppresses dots of characters whose attribute is set
// - inverse mode complements dots of characters whose attribute is set
// - normal mode shows the pattern with cursor when attribute is set
// - cursor follows the attribute in every mode and is never inverted
// - after reset scanning stays halted until the start command arrives, on a slave until the sync edge
// - only the master acts on start and pulses the slave sync output
// - display byte stored at pointer, then pointer increments
// - pointer wraps to zero when its increment would equal the grid count
// - control bytes follow prefix 0x01; other bytes are display data
// - commands 0x05, 0x06, 0x07 select 16, 32, 64 cycle slots
// - commands 0x08, 0x09, 0x0a select normal, blank, inverse mode
// - command 0x0e starts refresh; a repeat while running gives no second sync pulse
package dmr_pkg;

  // apb register byte addresses
  localparam logic [11:0] dmr_addr_data = 12'h000;
  localparam logic [11:0] dmr_addr_status = 12'h004;
  localparam logic [11:0] dmr_addr_config = 12'h008;

  // status word field positions
  localparam int dmr_st_run_pos = 0;
  localparam int dmr_st_mode_pos = 1;
  localparam int dmr_st_slot_pos = 3;
  localparam int dmr_st_duty_pos = 5;
  localparam int dmr_st_grid_pos = 11;
  localparam int dmr_st_ptr_pos = 16;
  localparam int dmr_st_scan_pos = 21;
  localparam int dmr_cfg_master_pos = 0;

  // command byte codes
  localparam logic [7:0] dmr_prefix = 8'h01;
  localparam logic [7:0] dmr_cmd_slot16 = 8'h05;
  localparam logic [7:0] dmr_cmd_slot32 = 8'h06;
  localparam logic [7:0] dmr_cmd_slot64 = 8'h07;
  localparam logic [7:0] dmr_cmd_normal = 8'h08;
  localparam logic [7:0] dmr_cmd_blank = 8'h09;
  localparam logic [7:0] dmr_cmd_inverse = 8'h0a;
  localparam logic [7:0] dmr_cmd_start = 8'h0e;
  localparam logic [7:0] dmr_cmd_ptr_last = 8'hd3;
  localparam logic [1:0] dmr_duty_top = 2'h1;
  localparam logic [2:0] dmr_grid_top = 3'h4;
  localparam logic [2:0] dmr_ptr_top = 3'h6;

  // timing in controller cycles
  localparam logic [6:0] dmr_slot16_len = 7'h10;
  localparam logic [6:0] dmr_slot32_len = 7'h20;
  localparam logic [6:0] dmr_slot64_len = 7'h40;
  localparam logic [6:0] dmr_gap_len = 7'h03;
  localparam logic [5:0] dmr_duty_offset = 6'h02;
  localparam logic [5:0] dmr_grid_full = 6'h20;

  // values after reset
  localparam logic [5:0] dmr_duty_rst = 6'h00;
  localparam logic [4:0] dmr_grid_rst = 5'h00;
  localparam logic [4:0] dmr_ptr_rst = 5'h00;
  localparam logic [6:0] dmr_cyc_rst = 7'h00;
  localparam logic [7:0] dmr_byte_rst = 8'h00;
  localparam logic dmr_master_rst = 1'b1;

  typedef enum logic [1:0] {dmr_slot16, dmr_slot32, dmr_slot64} dmr_slot_type;
  typedef enum logic [1:0] {dmr_mode_normal, dmr_mode_blank, dmr_mode_inverse} dmr_mode_type;
  typedef enum logic {dmr_halted, dmr_running} dmr_run_type;
  typedef enum logic [2:0] {
    dmr_do_none, dmr_do_data, dmr_do_slot, dmr_do_mode,
    dmr_do_start, dmr_do_duty, dmr_do_grid, dmr_do_ptr
  } dmr_cmd_type;

  function automatic logic [6:0] dmr_slot_len(input dmr_slot_type s);
    unique case (s)
      dmr_slot16: dmr_slot_len = dmr_slot16_len;
      dmr_slot32: dmr_slot_len = dmr_slot32_len;
      default: dmr_slot_len = dmr_slot64_len;
    endcase
  endfunction

  // zero grid count stands for a full 32 positions
  function automatic logic [5:0] dmr_grid_eff(input logic [4:0] g);
    dmr_grid_eff = (g == 5'h00) ? dmr_grid_full : {1'b0, g};
  endfunction

  function automatic logic [6:0] dmr_on_time(input logic [5:0] d, input dmr_slot_type s);
    logic [6:0] raw;
    logic [6:0] cap;
    raw = (d > dmr_duty_offset) ? {1'b0, d - dmr_duty_offset} : dmr_cyc_rst;
    cap = dmr_slot_len(s) - dmr_gap_len;
    dmr_on_time = (raw > cap) ? cap : raw;
  endfunction

endpackage

// *** hdl/dmr_cmd_decode.sv ***
// prefix tracking and classification of incoming control and display bytes
module dmr_cmd_decode (
  input wire logic sys_clk_in, // controller clock
  input wire logic nrst_in, // async reset, active low
  input wire logic byte_valid_in, // one-cycle strobe with a new byte
  input wire logic [7:0] byte_in, // byte from the host
  output dmr_pkg::dmr_cmd_type cmd_out, // decoded action, one cycle
  output logic [7:0] arg_out // byte that goes with cmd_out
);
  logic prefix_reg;

  function automatic dmr_pkg::dmr_cmd_type dmr_classify(input logic [7:0] b);
    if (b == dmr_pkg::dmr_prefix)
      dmr_classify = dmr_pkg::dmr_do_data;
    else if (b >= dmr_pkg::dmr_cmd_slot16 && b <= dmr_pkg::dmr_cmd_slot64)
      dmr_classify = dmr_pkg::dmr_do_slot;
    else if (b >= dmr_pkg::dmr_cmd_normal && b <= dmr_pkg::dmr_cmd_inverse)
      dmr_classify = dmr_pkg::dmr_do_mode;
    else if (b == dmr_pkg::dmr_cmd_start)
      dmr_classify = dmr_pkg::dmr_do_start;
    else if (b[7:6] == dmr_pkg::dmr_duty_top)
      dmr_classify = dmr_pkg::dmr_do_duty;
    else if (b[7:5] == dmr_pkg::dmr_grid_top)
      dmr_classify = dmr_pkg::dmr_do_grid;
    else if (b[7:5] == dmr_pkg::dmr_ptr_top && b <= dmr_pkg::dmr_cmd_ptr_last)
      dmr_classify = dmr_pkg::dmr_do_ptr;
    else
      dmr_classify = dmr_pkg::dmr_do_none;
  endfunction

  // a prefix arms the next byte as a command; prefix twice stores 0x01 as data
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      prefix_reg <= 1'b0;
    end else if (byte_valid_in) begin
      prefix_reg <= !prefix_reg && (byte_in == dmr_pkg::dmr_prefix);
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cmd_out <= dmr_pkg::dmr_do_none;
      arg_out <= dmr_pkg::dmr_byte_rst;
    end else if (byte_valid_in && prefix_reg) begin
      cmd_out <= dmr_classify(byte_in);
      arg_out <= byte_in;
    end else if (byte_valid_in && byte_in != dmr_pkg::dmr_prefix) begin
      cmd_out <= dmr_pkg::dmr_do_data;
      arg_out <= byte_in;
    end else begin
      cmd_out <= dmr_pkg::dmr_do_none;
    end
  end
endmodule

// *** hdl/dmr_scan_timer.sv ***
// slot cycle counter and scanned position counter
module dmr_scan_timer (
  input wire logic sys_clk_in, // controller clock
  input wire logic nrst_in, // async reset, active low
  input wire logic run_in, // refresh running
  input wire logic [6:0] slot_len_in, // cycles per slot
  input wire logic [6:0] on_time_in, // active cycles per slot
  input wire logic [5:0] grid_count_in, // positions scanned, 1..32
  output logic [4:0] pos_out, // position being scanned
  output logic active_out // drivers may be on this cycle
);
  logic [6:0] cyc_reg;
  logic [6:0] dark_reg;
  logic act_prev_reg;
  logic slot_end;

  // a burst only starts at slot start, so a duty or slot change cannot relight a dark slot
  assign active_out = run_in && (cyc_reg < on_time_in)
                      && (cyc_reg == dmr_pkg::dmr_cyc_rst || act_prev_reg);
  // a shortened slot ends at once, but never before three dark cycles have passed
  assign slot_end = run_in && !active_out && (dark_reg >= dmr_pkg::dmr_gap_len - 7'h01)
                    && (cyc_reg >= slot_len_in - 7'h01);

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      dark_reg <= dmr_pkg::dmr_cyc_rst;
      act_prev_reg <= 1'b0;
    end else begin
      act_prev_reg <= active_out;
      if (active_out)
        dark_reg <= dmr_pkg::dmr_cyc_rst;
      else if (dark_reg < dmr_pkg::dmr_gap_len)
        dark_reg <= dark_reg + 7'h01;
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cyc_reg <= dmr_pkg::dmr_cyc_rst;
    end else if (!run_in || slot_end) begin
      cyc_reg <= dmr_pkg::dmr_cyc_rst;
    end else begin
      cyc_reg <= cyc_reg + 7'h01;
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pos_out <= dmr_pkg::dmr_ptr_rst;
    end else if (slot_end) begin
      if ({1'b0, pos_out} + 6'h01 >= grid_count_in)
        pos_out <= dmr_pkg::dmr_ptr_rst;
      else
        pos_out <= pos_out + 5'h01;
    end
  end
endmodule

// *** verif/dmr_host_model.sv ***
// host processor model: apb master that issues display and control bytes
module dmr_host_model (
  input wire logic sys_clk_in, // controller clock
  input wire logic pready_in, // apb ready
  output logic psel_out, // apb select
  output logic penable_out, // apb access phase
  output logic pwrite_out, // apb direction
  output logic [11:0] paddr_out, // apb byte address
  output logic [31:0] pwdata_out // apb write data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    paddr_out = 12'h000;
    pwdata_out = 32'h0000_0000;
  end
  // enter just after a rising edge; leaves just after one with the bus idle
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel_out <= 1'b1;
    penable_out <= 1'b0;
    pwrite_out <= w;
    paddr_out <= a;
    pwdata_out <= d;
    @(posedge sys_clk_in);
    penable_out <= 1'b1;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (pready_in !== 1'b1 && n < 64);
    psel_out <= 1'b0;
    penable_out <= 1'b0;
    // released lines flip so a stale value never passes for a live one
    paddr_out <= ~a;
    pwdata_out <= ~d;
    @(posedge sys_clk_in);
  endtask
  task automatic send_byte(input logic [7:0] b);
    xfer(1'b1, dmr_pkg::dmr_addr_data, {24'h000000, b});
  endtask
  task automatic send_cmd(input logic [7:0] c);
    send_byte(dmr_pkg::dmr_prefix);
    send_byte(c);
  endtask
endmodule

// *** verif/dmr_refresh_top_tb_top.sv ***
// self-checking bench for the dot matrix refresh controller
module dmr_refresh_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_in, nrst_in, psel, penable, pwrite, pready, pslverr, sync_pulse;
  logic grid_act, dot_on, dot_inv, cursor, obs_req, sync_in;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, obs;
  logic [4:0] grid_sel;
  logic [6:0] code;
  logic [31:0] exp_q[$];
  int err_count, tests_run, sync_cnt;
  dmr_host_model u_host (.sys_clk_in(sys_clk_in), .pready_in(pready), .psel_out(psel), .penable_out(penable),
    .pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata));
  dmr_refresh_top u_dut (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .slave_sync_in(sync_in), .slave_sync_pulse_out(sync_pulse), .grid_sel_out(grid_sel),
    .grid_active_out(grid_act), .char_code_out(code), .dot_on_out(dot_on), .dot_invert_out(dot_inv),
    .cursor_out(cursor));
  task automatic tally_and_finish();
    if (err_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic take(input string what, input logic [31:0] seen);
    logic [31:0] want;
    want = (exp_q.size() > 0) ? exp_q.pop_front() : ~seen;
    tests_run++;
    if (seen !== want) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, want, seen);
    end
  endtask
  always @(posedge sys_clk_in) begin
    if (psel && penable && pready && !pwrite) take("apb read", {pslverr, prdata[30:0]});
    if (sync_pulse === 1'b1) sync_cnt++;
  end
  always @(posedge obs_req) take("scan", obs);
  task automatic rd(input logic [11:0] a, input logic [31:0] want);
    exp_q.push_back(want);
    u_host.xfer(1'b0, a, 32'h0000_0000);
  endtask
  task automatic note(input logic [31:0] v, input logic [31:0] want);
    exp_q.push_back(want);
    obs = v;
    obs_req = 1'b1;
    #1 obs_req = 1'b0;
    @(posedge sys_clk_in);
  endtask
  // sampled on the falling edge, clear of the registered output updates
  task automatic active_count(input int n, output int c);
    c = 0;
    repeat (n) begin
      @(negedge sys_clk_in);
      if (grid_act === 1'b1) c++;
    end
  endtask
  function automatic logic [31:0] st(input logic [1:0] s, input logic [4:0] g, input logic [4:0] p);
    st = (32'(p) << dmr_pkg::dmr_st_ptr_pos) | (32'(g) << dmr_pkg::dmr_st_grid_pos)
      | (32'(s) << dmr_pkg::dmr_st_slot_pos);
  endfunction
  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  initial begin
    #400_000;
    err_count++;
    tally_and_finish();
  end
  initial begin
    int c, i, k;
    logic [7:0] dc;
    logic [6:0] on, sl;
    nrst_in = 1'b0;
    err_count = 0;
    tests_run = 0;
    sync_cnt = 0;
    obs = 32'h0000_0000;
    obs_req = 1'b0;
    sync_in = 1'b0;
    c = $urandom(32'h8024);
    repeat (16) @(posedge sys_clk_in);
    nrst_in <= 1'b1;
    @(posedge sys_clk_in);
    rd(dmr_pkg::dmr_addr_status, st(2'h2, 5'h00, 5'h00));
    rd(dmr_pkg::dmr_addr_config, 32'h0000_0001);
    rd(12'h00c, 32'h8000_0000);
    u_host.send_cmd(8'h83);
    u_host.send_byte(8'h41);
    u_host.send_byte(8'hc2);
    u_host.send_byte(8'h43);
    rd(dmr_pkg::dmr_addr_status, st(2'h2, 5'h03, 5'h00));
    u_host.send_cmd(8'hc1);
    u_host.send_byte(8'hc4);
    rd(dmr_pkg::dmr_addr_status, st(2'h2, 5'h03, 5'h02));
    u_host.send_cmd(8'h0b);
    u_host.send_cmd(8'h20);
    u_host.send_cmd(8'he5);
    rd(dmr_pkg::dmr_addr_status, st(2'h2, 5'h03, 5'h02));
    u_host.send_cmd(8'h4f);
    active_count(200, c);
    note(32'(c), 32'h0000_0000);
    u_host.send_cmd(dmr_pkg::dmr_cmd_start);
    repeat (8) @(posedge sys_clk_in);
    note(32'(sync_cnt), 32'h0000_0001);
    u_host.send_cmd(dmr_pkg::dmr_cmd_start);
    repeat (8) @(posedge sys_clk_in);
    note(32'(sync_cnt), 32'h0000_0001);
    for (i = 0; i < 3; i++) begin
      dc = (i == 0) ? 8'h4f : (i == 1) ? (8'h40 | 8'($urandom % 64)) : 8'h7f;
      u_host.send_cmd(dmr_pkg::dmr_cmd_slot16 + 8'(i));
      u_host.send_cmd(dc);
      sl = 7'h10 << i;
      on = (dc[5:0] > 6'h02) ? 7'(dc[5:0]) - 7'h02 : 7'h00;
      if (on > sl - 7'h03) on = sl - 7'h03;
      repeat (3 * sl) @(posedge sys_clk_in);
      // any window of one slot length holds exactly one burst's worth of active cycles
      active_count(sl, c);
      note(32'(c), 32'(on));
    end
    for (i = 0; i < 3; i++) begin
      u_host.send_cmd(dmr_pkg::dmr_cmd_normal + 8'(i));
      repeat (4) @(posedge sys_clk_in);
      for (k = 0; k < 2; k++) begin
        c = 0;
        do begin
          @(negedge sys_clk_in);
          c++;
        end while (!(grid_act === 1'b1 && grid_sel === 5'(k)) && c < 500);
        note({22'h0, dot_on, dot_inv, cursor, code},
          {22'h0, (k == 0) || (i != 1), (k == 1) && (i == 2), k == 1, (k == 0) ? 7'h41 : 7'h44});
      end
    end
    // mid-run reset, then run as a slave: start code ignored, sync edge starts it
    nrst_in <= 1'b0;
    repeat (4) @(posedge sys_clk_in);
    nrst_in <= 1'b1;
    @(posedge sys_clk_in);
    note(32'({grid_act, cursor, dot_on, sync_pulse}), 32'h0000_0000);
    u_host.xfer(1'b1, dmr_pkg::dmr_addr_config, $urandom & 32'hffff_fffe);
    u_host.send_cmd(dmr_pkg::dmr_cmd_start);
    rd(dmr_pkg::dmr_addr_status, st(2'h2, 5'h00, 5'h00));
    sync_in <= 1'b1;
    repeat (4) @(posedge sys_clk_in);
    sync_in <= 1'b0;
    rd(dmr_pkg::dmr_addr_status, st(2'h2, 5'h00, 5'h00) | 32'h0000_0001);
    note(32'(sync_cnt), 32'h0000_0001);
    tally_and_finish();
  end
endmodule
